// ===== hdl/pus_top.sv
// pressure update sequencer with read-only serial result port
`timescale 1ns/100ps
module pus_top
   import pus_pkg::*;
#(
   parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
   parameter int unsigned UNLOCK_CYCLES  = UNLOCK_EXTRA_CYC,
   parameter int unsigned CONV_F_CYCLES  = CONV_FAST_CYC,
   parameter int unsigned CONV_S_CYCLES  = CONV_SLOW_CYC,
   parameter int unsigned PERIOD_SCALE   = SYS_CLK_HZ / 1_000_000
)
(
   // clock and power-on reset
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   // factory configuration
   input  wire pus_cfg_t    cfg_i,
   // measurement data from the converter path
   input  wire logic [13:0] bridge_data_i,
   input  wire logic [10:0] temp_data_i,
   // two-wire command events (same clock domain)
   input  wire logic        i2c_fetch_done_i,
   input  wire logic        i2c_meas_req_i,
   // serial peripheral pins
   input  wire logic        spi_sclk_i,
   input  wire logic        spi_sel_n_i,
   output logic             spi_miso_o,
   output logic             spi_miso_oe_o,
   // interrupt pin in two-wire mode
   output logic             int_o,
   // result and state view
   output pus_packet_t      result_o,
   output logic             converting_o,
   output logic             powered_down_o
);

   // ============================================================
   // parameter checks
   if (STARTUP_CYCLES < 1 || CONV_F_CYCLES < 1 || CONV_S_CYCLES < 1
       || PERIOD_SCALE < 1)
   begin : g_param_check
      $error("pus_top: counts must be at least one");
   end

   // ============================================================
   // pin synchronisers: three stages, change when 2nd and 3rd agree
   logic [2:0] sclk_q, sel_q;
   logic       sclk_s_q, sel_s_q, sclk_prev_q, sel_prev_q;

   // sync chains
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sclk_q <= 3'h0;
         sel_q  <= 3'h7;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], spi_sclk_i};
         sel_q  <= {sel_q[1:0], spi_sel_n_i};
      end
   end

   // filtered levels and previous values
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sclk_s_q    <= 1'b0;
         sel_s_q     <= 1'b1;
         sclk_prev_q <= 1'b0;
         sel_prev_q  <= 1'b1;
      end
      else
      begin
         if (sclk_q[1] == sclk_q[2])
            sclk_s_q <= sclk_q[2];
         if (sel_q[1] == sel_q[2])
            sel_s_q <= sel_q[2];
         sclk_prev_q <= sclk_s_q;
         sel_prev_q  <= sel_s_q;
      end
   end

   wire spi_en   = !cfg_i.iface_i2c && !cfg_i.cal_mode;
   wire sclk_fal = spi_en && sclk_prev_q && !sclk_s_q;
   wire sel_fall = spi_en && sel_prev_q && !sel_s_q;
   wire sel_rise = spi_en && !sel_prev_q && sel_s_q;
   wire spi_busy = spi_en && !sel_s_q;

   // ============================================================
   // select low-time counter for the serial trigger
   logic [15:0] sel_low_q;
   logic        trig_ok;

   // count while select stays low
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         sel_low_q <= 16'h0000;
      else if (sel_s_q)
         sel_low_q <= 16'h0000;
      else if (sel_low_q != 16'hFFFF)
         sel_low_q <= sel_low_q + 16'h0001;
   end

   assign trig_ok = sel_rise && (sel_low_q >= 16'(REQ_LOW_CYC));

   // ============================================================
   // sequencer timing
   pus_seq_t    seq_q;
   logic [31:0] tmr_q;
   logic [7:0]  ord_cnt_q;
   logic        startup_done_q;
   logic        first_done_q;
   logic        write_req_q;
   logic [31:0] conv_cyc, period_cyc, gap_cyc;
   logic        meas_req;

   assign conv_cyc = cfg_i.clk_div4 ? CONV_S_CYCLES : CONV_F_CYCLES;

   // period from rate field and clock
   assign period_cyc = (cfg_i.clk_div4 ? PERIOD_US_SLOW[cfg_i.rate]
                                       : PERIOD_US_FAST[cfg_i.rate])
                       * PERIOD_SCALE;

   // default code 00 is the fastest rate
   assign gap_cyc = (cfg_i.rate == RATE_RESET) ? 32'h0000_0000
                    : ((period_cyc > conv_cyc) ? period_cyc - conv_cyc
                                               : 32'h0000_0000);

   assign meas_req = i2c_meas_req_i || trig_ok;

   logic [31:0] startup_len;
   assign startup_len = cfg_i.cfg_locked ? STARTUP_CYCLES
                                         : STARTUP_CYCLES + UNLOCK_CYCLES;

   // main measurement sequence
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         seq_q          <= SQ_STARTUP;
         tmr_q          <= 32'h0000_0000;
         ord_cnt_q      <= 8'h00;
         startup_done_q <= 1'b0;
         first_done_q   <= 1'b0;
         write_req_q    <= 1'b0;
      end
      else
      begin
         write_req_q <= 1'b0;
         case (seq_q)
            SQ_STARTUP:
            begin
               tmr_q <= tmr_q + 32'h0000_0001;
               if (!first_done_q && tmr_q + 32'h1 >= startup_len)
               begin
                  first_done_q   <= 1'b1;
                  startup_done_q <= 1'b1;
                  tmr_q          <= 32'h0000_0000;
                  seq_q          <= SQ_SPECIAL;
               end
            end
            SQ_IDLE:
            begin
               tmr_q <= 32'h0000_0000;
               if (cfg_i.mode_update)
                  seq_q <= SQ_BRIDGE;
               else if (meas_req)
                  seq_q <= SQ_SPECIAL;
            end
            SQ_SPECIAL:
            begin
               if (tmr_q + 32'h1 >= conv_cyc)
               begin
                  tmr_q <= 32'h0000_0000;
                  seq_q <= SQ_BRIDGE;
               end
               else
                  tmr_q <= tmr_q + 32'h0000_0001;
            end
            SQ_BRIDGE:
            begin
               if (tmr_q + 32'h1 >= conv_cyc)
               begin
                  tmr_q <= 32'h0000_0000;
                  seq_q <= SQ_CALC;
               end
               else
                  tmr_q <= tmr_q + 32'h0000_0001;
            end
            SQ_CALC:
            begin
               // hold result until select is high
               if (!spi_busy)
               begin
                  write_req_q <= 1'b1;
                  tmr_q       <= 32'h0000_0000;
                  if (!cfg_i.mode_update)
                     seq_q <= SQ_IDLE;
                  else if (gap_cyc == 32'h0)
                     seq_q <= SQ_POWDN;
                  else
                     seq_q <= SQ_POWDN;
               end
            end
            SQ_POWDN:
            begin
               // wait out gap, then next cycle
               if (tmr_q >= gap_cyc)
               begin
                  tmr_q <= 32'h0000_0000;
                  // special after set count of cycles
                  if (ord_cnt_q >= SPECIAL_EVERY[cfg_i.rate])
                  begin
                     ord_cnt_q <= 8'h00;
                     seq_q     <= SQ_SPECIAL;
                  end
                  else
                  begin
                     ord_cnt_q <= ord_cnt_q + 8'h01;
                     seq_q     <= SQ_BRIDGE;
                  end
               end
               else
                  tmr_q <= tmr_q + 32'h0000_0001;
            end
            default:
               seq_q <= SQ_STARTUP;
         endcase
      end
   end

   assign converting_o   = (seq_q == SQ_SPECIAL) || (seq_q == SQ_BRIDGE)
                           || (seq_q == SQ_CALC);
   assign powered_down_o = (seq_q == SQ_POWDN && gap_cyc != 32'h0)
                           || seq_q == SQ_IDLE;

   // ============================================================
   // output register and status
   pus_packet_t res_q;
   logic        fetch_done;

   // fetch completes when select rises or two-wire read ends
   assign fetch_done = i2c_fetch_done_i || sel_rise;

   // result data only changes on a write, status also goes stale on a fetch
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         res_q <= '{status: ST_STALE, default: '0};
      else if (write_req_q)
      begin
         // new result wins over a coincident fetch
         res_q.status <= ST_VALID;
         res_q.bridge <= bridge_data_i;
         res_q.temp   <= temp_data_i;
         res_q.pad    <= 5'h00;
      end
      else if (fetch_done && startup_done_q)
         res_q.status <= ST_STALE;
   end
   assign result_o = res_q;

   // interrupt rises on new data, two-wire only
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         int_o <= 1'b0;
      else if (!cfg_i.iface_i2c)
         int_o <= 1'b0;
      else if (write_req_q)
         int_o <= 1'b1;
      else if (i2c_fetch_done_i)
         int_o <= 1'b0;
   end

   // ============================================================
   // serial shifter: transmit only, no receive path
   logic [PKT_BITS-1:0] shift_q;
   logic                first_bit_q;

   // load on select fall, shift on fall
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         shift_q     <= '0;
         first_bit_q <= 1'b0;
      end
      else if (sel_fall)
      begin
         shift_q     <= res_q;
         first_bit_q <= 1'b1;
      end
      else if (sclk_fal && spi_busy)
         shift_q <= {shift_q[PKT_BITS-2:0], 1'b0};
   end

   // miso register
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         spi_miso_o <= 1'b0;
      else
         spi_miso_o <= shift_q[PKT_BITS-1];
   end

   assign spi_miso_oe_o = spi_busy && first_bit_q;

endmodule

// ===== inc/pus_pkg.sv
// package for the pressure update sequencer and serial result port
package pus_pkg;

   // ============================================================
   // clock and timing
   localparam int unsigned SYS_CLK_HZ       = 10_000_000;
   localparam int unsigned STARTUP_US       = 10_000;   // 10 ms start-up
   localparam int unsigned FIRST_RESULT_US  = 6_000;    // 6 ms first result
   localparam int unsigned UNLOCK_EXTRA_US  = 4_500;    // 4.5 ms extension
   localparam int unsigned CONV_US_FAST     = 250;      // one conversion, 4 MHz
   localparam int unsigned CONV_US_SLOW     = 800;      // one conversion, 1 MHz
   localparam int unsigned REQ_LOW_NS       = 8_000;    // select low for trigger
   localparam int unsigned STARTUP_CYC      = STARTUP_US * (SYS_CLK_HZ / 1_000_000);
   localparam int unsigned FIRST_RESULT_CYC = FIRST_RESULT_US * (SYS_CLK_HZ / 1_000_000);
   localparam int unsigned UNLOCK_EXTRA_CYC = UNLOCK_EXTRA_US * (SYS_CLK_HZ / 1_000_000);
   localparam int unsigned CONV_FAST_CYC    = CONV_US_FAST * (SYS_CLK_HZ / 1_000_000);
   localparam int unsigned CONV_SLOW_CYC    = CONV_US_SLOW * (SYS_CLK_HZ / 1_000_000);
   localparam int unsigned REQ_LOW_CYC      = (REQ_LOW_NS * (SYS_CLK_HZ / 1_000_000)
                                               + 999) / 1000;

   // update periods in microseconds, typical (index = rate code)
   localparam int unsigned PERIOD_US_FAST [4] = '{500, 1_500, 6_500, 32_000};
   localparam int unsigned PERIOD_US_SLOW [4] = '{1_600, 5_000, 25_000, 125_000};
   // ordinary cycles between special measurements
   localparam logic [7:0]  SPECIAL_EVERY  [4] = '{8'hFF, 8'h7F, 8'h1F, 8'h0F};

   // ============================================================
   // configuration word layout
   localparam int unsigned CFG_RATE_WORD = 1;     // word 01 hex
   localparam int unsigned CFG_RATE_MSB  = 7;
   localparam int unsigned CFG_RATE_LSB  = 6;
   localparam logic [1:0]  RATE_RESET    = 2'h0;  // factory default code 00

   // ============================================================
   // result packet layout
   localparam int unsigned PKT_BITS  = 32;
   localparam logic [1:0]  ST_VALID  = 2'h0;
   localparam logic [1:0]  ST_STALE  = 2'h2;

   typedef struct packed {
      logic [1:0]  status;
      logic [13:0] bridge;
      logic [10:0] temp;
      logic [4:0]  pad;
   } pus_packet_t;

   typedef struct packed {
      logic        mode_update;  // 1 = periodic, 0 = triggered sleep
      logic        clk_div4;     // 1 = 1 MHz core clock
      logic        cfg_locked;
      logic        iface_i2c;    // 1 = two-wire, 0 = serial peripheral
      logic        cal_mode;     // calibration command state
      logic [1:0]  rate;
   } pus_cfg_t;

   typedef enum logic [2:0] {
      SQ_STARTUP = 3'b000,
      SQ_IDLE    = 3'b001,
      SQ_SPECIAL = 3'b010,
      SQ_BRIDGE  = 3'b011,
      SQ_CALC    = 3'b100,
      SQ_POWDN   = 3'b101
   } pus_seq_t;

endpackage

// ===== testbench/pus_props.sv
// concurrent checks on the update sequencer ports
`timescale 1ns/100ps
// ============================================================
// checker
module pus_props
   import pus_pkg::*;
#(
   parameter int unsigned STARTUP_CYCLES = 50,
   parameter int unsigned UNLOCK_CYCLES  = 20,
   parameter int unsigned CONV_S_CYCLES  = 8
)
(
   // clock and reset
   input wire logic        clk_sys_i,
   input wire logic        sys_rst_i,
   // stimulus side
   input wire pus_cfg_t    cfg_i,
   input wire logic        i2c_fetch_done_i,
   input wire logic        i2c_meas_req_i,
   input wire logic        spi_sel_n_i,
   // design outputs
   input wire logic        spi_miso_oe_o,
   input wire logic        int_o,
   input wire pus_packet_t result_o,
   input wire logic        powered_down_o
);
   localparam int LIM = STARTUP_CYCLES + UNLOCK_CYCLES + 4 * CONV_S_CYCLES + 64;
   int   cyc_q;
   logic seen_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // cycles since reset and first valid result flag
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
      if (sys_rst_i)
      begin
         cyc_q  <= 0;
         seen_q <= 1'b0;
      end
      else
      begin
         if (cyc_q <= LIM)
            cyc_q <= cyc_q + 1;
         if (result_o.status == ST_VALID)
            seen_q <= 1'b1;
      end
   AST_OE_CAL: assert property (cfg_i.cal_mode |-> !spi_miso_oe_o)
      else $error("serial output on in calibration state");
   AST_FIRST: assert property (cyc_q == LIM && !cfg_i.cal_mode |-> seen_q)
      else $error("no first result in time");
   AST_FAST: assert property (
      cfg_i.mode_update && cfg_i.rate == 2'h0 |-> !powered_down_o)
      else $error("power down at fastest rate");
   AST_SLEEP: assert property (
      spi_sel_n_i [*8] ##0 (powered_down_o && !cfg_i.mode_update
      && !(i2c_meas_req_i || $past(i2c_meas_req_i)
      || $past(i2c_meas_req_i, 2))) |=> powered_down_o)
      else $error("woke without request");
   AST_TRIG: assert property (
      i2c_meas_req_i && cfg_i.iface_i2c && powered_down_o
      && !cfg_i.mode_update |-> ##[1:4] !powered_down_o)
      else $error("request did not wake");
   AST_HOLD: assert property (
      cfg_i.iface_i2c && powered_down_o && $past(powered_down_o)
      && $past(powered_down_o, 2)
      |-> $stable(result_o.bridge) && $stable(result_o.temp))
      else $error("result changed while powered down");
   AST_STALE: assert property (
      i2c_fetch_done_i && cfg_i.iface_i2c && powered_down_o
      |-> ##[1:2] result_o.status == ST_STALE)
      else $error("status not stale after fetch");
   AST_NO_TEAR: assert property ((!spi_sel_n_i) [*8] |-> $stable(result_o))
      else $error("result changed during serial fetch");
   AST_INT: assert property (!cfg_i.iface_i2c |-> !int_o)
      else $error("interrupt in serial mode");
   // main scenarios reached
   COV_WAKE: cover property (powered_down_o ##1 !powered_down_o);
   COV_INT: cover property ($rose(int_o));
   COV_OE: cover property ($rose(spi_miso_oe_o));
endmodule
bind pus_top pus_props #(.STARTUP_CYCLES(STARTUP_CYCLES),
   .UNLOCK_CYCLES(UNLOCK_CYCLES), .CONV_S_CYCLES(CONV_S_CYCLES))
   pus_props_i (.clk_sys_i, .sys_rst_i, .cfg_i, .i2c_fetch_done_i,
   .i2c_meas_req_i, .spi_sel_n_i, .spi_miso_oe_o, .int_o, .result_o,
   .powered_down_o);

// ===== testbench/pus_spi_host.sv
// serial master model that fetches packets and sends triggers
`timescale 1ns/100ps
module pus_spi_host #(
   parameter int HALF = 30
)
(
   // clock
   input  wire logic clk_i,
   // serial pins
   output logic      sclk_o,
   output logic      sel_n_o,
   input  wire logic miso_i,
   input  wire logic oe_i,
   // drive seen in last frame
   output logic      saw_oe_o
);
   // idle pins, clock stands low outside frames so the first edge is a rise
   initial
   begin
      sclk_o   = 1'b0;
      sel_n_o  = 1'b1;
      saw_oe_o = 1'b0;
   end
   // sample as the clock rises, data moves after fall, clock slow
   task automatic xfer(input int nbits, output logic [31:0] d);
      d = '0;
      saw_oe_o = 1'b0;
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
      for (int b = 31; b > 31 - nbits; b--)
      begin
         d[b] = miso_i;
         saw_oe_o = saw_oe_o | (oe_i === 1'b1);
         sclk_o <= 1'b1;
         repeat (HALF) @(posedge clk_i);
         sclk_o <= 1'b0;
         repeat (HALF) @(posedge clk_i);
      end
      sel_n_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
   endtask
   // select low past 8 us, then raised
   task automatic trig();
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      repeat (100) @(posedge clk_i);
      sel_n_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
   endtask
endmodule

// ===== testbench/pus_top_tb.sv
// self-checking bench for the pressure update sequencer
`timescale 1ns/100ps
module pus_top_tb;
   import pus_pkg::*;
   // ============================================================
   // signals
   logic        clk_sys_i        = 1'b0;
   logic        sys_rst_i        = 1'b1;
   pus_cfg_t    cfg_i            = '0;
   logic [13:0] bridge_data_i    = 14'h2A5C;
   logic [10:0] temp_data_i      = 11'h5B3;
   logic        i2c_fetch_done_i = 1'b0;
   logic        i2c_meas_req_i   = 1'b0;
   logic        sclk;
   logic        sel_n;
   logic        miso;
   logic        miso_oe;
   logic        int_o;
   logic        pd;
   logic        conv;
   logic        saw_oe;
   pus_packet_t result;
   logic [31:0] pkt;
   int          fail_count = 0;
   int          n_compared = 0;
   // 10 MHz system clock
   initial
      forever
         #50 clk_sys_i = ~clk_sys_i;
   // design and serial master
   pus_top #(.STARTUP_CYCLES(50), .UNLOCK_CYCLES(20), .CONV_F_CYCLES(5),
      .CONV_S_CYCLES(8), .PERIOD_SCALE(1)) pus_top_i (.clk_sys_i,
      .sys_rst_i, .cfg_i, .bridge_data_i, .temp_data_i, .i2c_fetch_done_i,
      .i2c_meas_req_i, .spi_sclk_i(sclk), .spi_sel_n_i(sel_n),
      .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .int_o, .result_o(result),
      .converting_o(conv), .powered_down_o(pd));
   pus_spi_host pus_spi_host_i (.clk_i(clk_sys_i), .sclk_o(sclk),
      .sel_n_o(sel_n), .miso_i(miso), .oe_i(miso_oe), .saw_oe_o(saw_oe));
   // ============================================================
   // shared tasks
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   // wait for power down (0) or interrupt (1)
   task automatic wait_hi(input bit w, input int bound);
      for (int k = 0; k < bound; k++)
      begin
         @(negedge clk_sys_i);
         if ((w ? int_o : pd) === 1'b1)
            return;
      end
      fail_count++;
      $display("ERROR wait expected 1 seen timeout");
      stop_test();
   endtask
   task automatic boot(input pus_cfg_t c);
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      cfg_i     <= c;
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
   endtask
   // one-cycle fetch (1) or request (0) pulse
   task automatic pulse(input bit f);
      @(posedge clk_sys_i);
      i2c_fetch_done_i <= f;
      i2c_meas_req_i   <= !f;
      @(posedge clk_sys_i);
      i2c_fetch_done_i <= 1'b0;
      i2c_meas_req_i   <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
   endtask
   // ============================================================
   // scenarios
   task automatic t_sleep_spi();
      boot(pus_cfg_t'{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0});
      repeat (30) @(negedge clk_sys_i);
      chk("early status", ST_STALE, result.status);
      wait_hi(1'b0, 400);
      pus_spi_host_i.xfer(32, pkt);
      chk("status", ST_VALID, pkt[31:30]);
      chk("bridge", 14'h2A5C, pkt[29:16]);
      chk("temp", 11'h5B3, pkt[15:5]);
      chk("oe", 1'b1, saw_oe);
      chk("asleep", 1'b1, pd);
      chk("idle converting", 1'b0, conv);
      @(posedge clk_sys_i);
      bridge_data_i <= 14'h1357;
      pus_spi_host_i.trig();
      wait_hi(1'b0, 400);
      pus_spi_host_i.xfer(16, pkt);
      chk("new status", ST_VALID, pkt[31:30]);
      chk("new bridge", 14'h1357, pkt[29:16]);
      $display("test sleep_spi done");
   endtask
   task automatic t_i2c();
      boot(pus_cfg_t'{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0});
      bridge_data_i <= 14'h0F0F;
      repeat (65) @(negedge clk_sys_i);
      chk("int early", 1'b0, int_o);
      wait_hi(1'b1, 600);
      chk("int data", {ST_VALID, 14'h0F0F}, result[31:16]);
      pus_spi_host_i.xfer(8, pkt);
      chk("oe two-wire", 1'b0, saw_oe);
      pulse(1'b1);
      chk("int cleared", 1'b0, int_o);
      chk("stale", ST_STALE, result.status);
      pulse(1'b0);
      chk("converting", 1'b1, conv);
      wait_hi(1'b1, 300);
      chk("valid again", ST_VALID, result.status);
      $display("test i2c done");
   endtask
   task automatic t_cal();
      boot(pus_cfg_t'{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0});
      repeat (200) @(posedge clk_sys_i);
      pus_spi_host_i.xfer(8, pkt);
      chk("oe calibration", 1'b0, saw_oe);
      $display("test cal done");
   endtask
   task automatic t_rate();
      int n;
      bit seen;
      int per;
      for (int r = 0; r < 3; r++)
      begin
         boot(pus_cfg_t'{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, r[1:0]});
         per = PERIOD_US_FAST[r];
         wait_hi(1'b1, 3000);
         // one fetch per update, paced by the interrupt
         pulse(1'b1);
         n = 3;
         seen = 1'b0;
         while (int_o !== 1'b1 && n < 2 * per)
         begin
            @(negedge clk_sys_i);
            n++;
            seen = seen | (pd === 1'b1);
         end
         if (r != 0)
            chk("period", 1'b1, n >= per * 85 / 100 && n <= per * 115 / 100);
         chk("power down", r != 0, seen);
      end
      $display("test rate done");
   endtask
   // main sequence
   initial
   begin
      t_sleep_spi();
      t_i2c();
      t_cal();
      t_rate();
      stop_test();
   end
endmodule
